// File: hdl/via_map.svh
/*
 * Address map, vector codes, reset values and timing counts of the
 * vectored interrupt arbiter.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef VIA_MAP_SVH
`define VIA_MAP_SVH

// APB register byte offsets
`define VIA_OFS_CTRL 8'h00
`define VIA_OFS_PEND 8'h04
`define VIA_OFS_STAT 8'h08
`define VIA_OFS_WAKE_ENABLE_REG 8'h0c
`define VIA_OFS_WAKE_EDGE_SELECT_REG 8'h10
`define VIA_OFS_WAKE_PENDING_REG 8'h14

// Control register fields
`define VIA_CTRL_GIE 0
`define VIA_CTRL_WKIE 1
`define VIA_CTRL_EXTFALL 2
`define VIA_CTRL_EN_LO 8
`define VIA_CTRL_EN_HI 13

// Status register fields
`define VIA_STAT_BUSY 8
`define VIA_STAT_WAKE 9

// Reset values
`define VIA_RST_BYTE 8'h00
`define VIA_RST_SRC 6'h00

// Maskable source indexes in the pending and enable vectors
`define VIA_SRC_EXT 0
`define VIA_SRC_T0 1
`define VIA_SRC_T1A 2
`define VIA_SRC_T1B 3
`define VIA_SRC_SER 4
`define VIA_SRC_EE 5

// Low vector table address bytes produced by the arbiter
`define VIA_VEC_TRAP 8'hfe
`define VIA_VEC_EXT 8'hfa
`define VIA_VEC_T0 8'hf8
`define VIA_VEC_T1A 8'hf6
`define VIA_VEC_T1B 8'hf4
`define VIA_VEC_SER 8'hf2
`define VIA_VEC_EE 8'hf0
`define VIA_VEC_WAKE 8'he2
`define VIA_VEC_DEFAULT 8'he0

// Core related constants
`define VIA_TRAP_OPCODE 8'h00
`define VIA_SP_LIMIT 8'h6f
`define VIA_PC_OVERFLOW 15'h7fff
`define VIA_PC_ACK 15'h00ff
`define VIA_BLOCK_LAST 8'hff
`define VIA_ACK_CYCLES 3'd7
`define VIA_ACK_CNT_ONE 3'd1
`define VIA_PC_ONE 15'h0001
`define VIA_BLK_ONE 7'h01

`endif

// File: hdl/via_pkg.sv
/*
 * Types shared by the vectored interrupt arbiter and its bench.
 * Assumes via_map.svh is on the include path.
 */
package via_pkg;
    `include "via_map.svh"

    // Per-instruction strobes from the core sequencer
    typedef struct packed {
        logic instr_start;
        logic [14:0] instr_addr;
        logic [7:0] opcode;
        logic vectored_select_instr;
        logic clear_trap_pending_instr;
        logic return_from_irq_instr;
        logic pop;
        logic [7:0] sp;
    } via_core_s;

    // Program counter load towards the core
    typedef struct packed {
        logic load;
        logic [14:0] value;
    } via_pc_s;

    // Stack push towards the core
    typedef struct packed {
        logic push;
        logic [14:0] addr;
    } via_push_s;

    typedef enum logic [4:0] {
        VIA_IDLE = 5'b00001,
        VIA_ACK = 5'b00010,
        VIA_VHI = 5'b00100,
        VIA_VLO = 5'b01000,
        VIA_VDONE = 5'b10000
    } via_state_e;
endpackage

// File: hdl/via_arbiter.sv
/*
 * Interrupt arbitration, acknowledge sequencing, vectored select, software
 * trap and wake port logic of an 8-bit controller core.
 * Assumes the core sequencer stalls while BUSY_O is high, gives one
 * instr_start per instruction, and program memory answers one cycle after
 * PMEM_RD_O. One clock cycle stands for one instruction cycle.
 */
// Our own choices: register access over APB and the register offsets.
`include "via_map.svh"

module via_arbiter
    import via_pkg::*;
#(
    parameter int PROG_BYTES = 32768
) (
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire via_core_s CORE_I,
    output via_pc_s PC_O,
    output via_push_s PUSH_O,
    output logic BUSY_O,
    output logic [14:0] PMEM_ADDR_O,
    output logic PMEM_RD_O,
    input wire logic [7:0] PMEM_DATA_I,
    input wire logic [4:0] SRC_EVT_I,
    input wire logic EXT_IRQ_PIN_I,
    input wire logic [7:0] WAKE_PIN_I,
    output logic WAKEUP_O
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic gie_r;
    logic wkie_r;
    logic ext_fall_r;
    logic [5:0] src_en_r;
    logic [5:0] src_pend_r;
    logic [7:0] wake_en_r;
    logic [7:0] wake_edge_r;
    logic [7:0] wake_pend_r;
    logic trap_pend_r;
    logic [8:0] sync1_r;
    logic [8:0] sync2_r;
    logic [8:0] sync3_r;
    logic [8:0] filt_r;
    logic [8:0] filt_nxt;
    logic [8:0] rise;
    logic [8:0] fall;
    logic [7:0] wake_hit;
    logic ext_hit;
    via_state_e state_r;
    via_state_e state_nxt;
    logic [2:0] ack_cnt_r;
    logic [14:0] vec_addr_r;
    logic [6:0] vec_hi_r;
    logic [7:0] pmem_data;
    logic pmem_ok_r;
    logic [5:0] src_act;
    logic wake_act;
    logic [7:0] arb_code;
    logic opcode_trap;
    logic trap_evt;
    logic mask_ack;
    logic [7:0] vis_blk_hi;
    logic wr_en;
    logic rd_setup;
    logic addr_hit;
    logic [5:0] src_pend_set;
    logic [5:0] src_pend_clr;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
    assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    always_comb begin
        unique case (PADDR_I)
            `VIA_OFS_CTRL, `VIA_OFS_PEND, `VIA_OFS_STAT,
            `VIA_OFS_WAKE_ENABLE_REG, `VIA_OFS_WAKE_EDGE_SELECT_REG, `VIA_OFS_WAKE_PENDING_REG: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_hit;

    // Read data captured in the setup phase; trap flag has no address
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            PRDATA_O <= 32'h0000_0000;
        end else if (rd_setup) begin
            PRDATA_O <= 32'h0000_0000;
            unique case (PADDR_I)
                `VIA_OFS_CTRL: begin
                    PRDATA_O[`VIA_CTRL_GIE] <= gie_r;
                    PRDATA_O[`VIA_CTRL_WKIE] <= wkie_r;
                    PRDATA_O[`VIA_CTRL_EXTFALL] <= ext_fall_r;
                    PRDATA_O[`VIA_CTRL_EN_HI:`VIA_CTRL_EN_LO] <= src_en_r;
                end
                `VIA_OFS_PEND: PRDATA_O[5:0] <= src_pend_r;
                `VIA_OFS_STAT: begin
                    PRDATA_O[7:0] <= arb_code;
                    PRDATA_O[`VIA_STAT_BUSY] <= BUSY_O;
                    PRDATA_O[`VIA_STAT_WAKE] <= WAKEUP_O;
                end
                `VIA_OFS_WAKE_ENABLE_REG: PRDATA_O[7:0] <= wake_en_r;
                `VIA_OFS_WAKE_EDGE_SELECT_REG: PRDATA_O[7:0] <= wake_edge_r;
                `VIA_OFS_WAKE_PENDING_REG: PRDATA_O[7:0] <= wake_pend_r;
                default: PRDATA_O <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register; hardware updates of the enable win over writes
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            gie_r <= 1'b0;
            wkie_r <= 1'b0;
            ext_fall_r <= 1'b0;
            src_en_r <= `VIA_RST_SRC;
        end else begin
            if (wr_en && PADDR_I == `VIA_OFS_CTRL) begin
                gie_r <= PWDATA_I[`VIA_CTRL_GIE];
                wkie_r <= PWDATA_I[`VIA_CTRL_WKIE];
                ext_fall_r <= PWDATA_I[`VIA_CTRL_EXTFALL];
                src_en_r <= PWDATA_I[`VIA_CTRL_EN_HI:`VIA_CTRL_EN_LO];
            end
            if (mask_ack) begin
                gie_r <= 1'b0;
            end else if (CORE_I.return_from_irq_instr && !BUSY_O) begin
                gie_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, three stages, change taken when stages 2 and 3 agree
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            sync1_r <= 9'h000;
            sync2_r <= 9'h000;
            sync3_r <= 9'h000;
            filt_r <= 9'h000;
        end else begin
            sync1_r <= {EXT_IRQ_PIN_I, WAKE_PIN_I};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            filt_r <= filt_nxt;
        end
    end
    always_comb begin
        for (int i = 0; i < 9; i++) begin
            filt_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : filt_r[i];
        end
    end
    assign rise = filt_nxt & ~filt_r;
    assign fall = ~filt_nxt & filt_r;
    assign wake_hit = (wake_edge_r & fall[7:0]) | (~wake_edge_r & rise[7:0]);
    assign ext_hit = ext_fall_r ? fall[8] : rise[8];

    ////////////////////////////////////////////////////////////////////////
    // Wake port registers; an edge in the clearing cycle stays pending
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            wake_en_r <= `VIA_RST_BYTE;
            wake_edge_r <= `VIA_RST_BYTE;
            wake_pend_r <= `VIA_RST_BYTE;
        end else begin
            if (wr_en && PADDR_I == `VIA_OFS_WAKE_ENABLE_REG) begin
                wake_en_r <= PWDATA_I[7:0];
            end
            if (wr_en && PADDR_I == `VIA_OFS_WAKE_EDGE_SELECT_REG) begin
                wake_edge_r <= PWDATA_I[7:0];
            end
            if (wr_en && PADDR_I == `VIA_OFS_WAKE_PENDING_REG) begin
                wake_pend_r <= (wake_pend_r & ~PWDATA_I[7:0]) | wake_hit;
            end else begin
                wake_pend_r <= wake_pend_r | wake_hit;
            end
        end
    end

    // Wake from halt or idle, with or without the interrupt
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            WAKEUP_O <= 1'b0;
        end else begin
            WAKEUP_O <= |(wake_en_r & wake_pend_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Maskable pending bits, write one to clear, set wins
    assign src_pend_set = {SRC_EVT_I, ext_hit};
    assign src_pend_clr = (wr_en && PADDR_I == `VIA_OFS_PEND) ? PWDATA_I[5:0] : 6'h00;
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            src_pend_r <= `VIA_RST_SRC;
        end else begin
            src_pend_r <= (src_pend_r & ~src_pend_clr) | src_pend_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Arbiter, purely combinational over enables and pending bits
    assign src_act = src_en_r & src_pend_r;
    assign wake_act = wkie_r & |(wake_en_r & wake_pend_r);
    always_comb begin
        if (trap_pend_r) begin
            arb_code = `VIA_VEC_TRAP;
        end else if (src_act[`VIA_SRC_EXT]) begin
            arb_code = `VIA_VEC_EXT;
        end else if (src_act[`VIA_SRC_T0]) begin
            arb_code = `VIA_VEC_T0;
        end else if (src_act[`VIA_SRC_T1A]) begin
            arb_code = `VIA_VEC_T1A;
        end else if (src_act[`VIA_SRC_T1B]) begin
            arb_code = `VIA_VEC_T1B;
        end else if (src_act[`VIA_SRC_SER]) begin
            arb_code = `VIA_VEC_SER;
        end else if (src_act[`VIA_SRC_EE]) begin
            arb_code = `VIA_VEC_EE;
        end else if (wake_act) begin
            arb_code = `VIA_VEC_WAKE;
        end else begin
            arb_code = `VIA_VEC_DEFAULT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trap detection and acknowledge conditions
    assign opcode_trap = ({1'b0, CORE_I.instr_addr} >= 16'(PROG_BYTES)) ||
                         (CORE_I.opcode == `VIA_TRAP_OPCODE);
    assign trap_evt = CORE_I.instr_start && opcode_trap && state_r != VIA_ACK;
    // Maskable acknowledge only with enable set and no trap pending
    assign mask_ack = CORE_I.instr_start && !opcode_trap && state_r == VIA_IDLE &&
                      gie_r && !trap_pend_r &&
                      ((|src_act) || (wake_act && gie_r));

    // Trap pending flag; a new trap wins over the clear instruction
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            trap_pend_r <= 1'b0;
        end else if (trap_evt) begin
            trap_pend_r <= 1'b1;
        end else if (CORE_I.clear_trap_pending_instr && !BUSY_O) begin
            trap_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    assign vis_blk_hi = (CORE_I.instr_addr[7:0] == `VIA_BLOCK_LAST) ?
                        {1'b0, CORE_I.instr_addr[14:8] + `VIA_BLK_ONE} :
                        {1'b0, CORE_I.instr_addr[14:8]};
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            VIA_IDLE: begin
                if (trap_evt || mask_ack) begin
                    state_nxt = VIA_ACK;
                end else if (CORE_I.vectored_select_instr) begin
                    state_nxt = VIA_VHI;
                end
            end
            VIA_ACK: begin
                if (ack_cnt_r == `VIA_ACK_CYCLES) begin
                    state_nxt = VIA_IDLE;
                end
            end
            VIA_VHI: state_nxt = VIA_VLO;
            VIA_VLO: state_nxt = VIA_VDONE;
            VIA_VDONE: state_nxt = VIA_IDLE;
            default: state_nxt = VIA_IDLE;
        endcase
    end
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            state_r <= VIA_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end
    assign BUSY_O = state_r != VIA_IDLE;

    // Acknowledge cycle count
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            ack_cnt_r <= 3'd0;
        end else if (state_r == VIA_IDLE) begin
            ack_cnt_r <= `VIA_ACK_CNT_ONE;
        end else if (state_r == VIA_ACK) begin
            ack_cnt_r <= ack_cnt_r + `VIA_ACK_CNT_ONE;
        end
    end

    // Stack push of the return address
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            PUSH_O <= '0;
        end else begin
            PUSH_O.push <= state_r == VIA_IDLE && (trap_evt || mask_ack);
            PUSH_O.addr <= CORE_I.instr_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Vector table fetch; nonexistent memory reads as zero
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            vec_addr_r <= 15'h0000;
            vec_hi_r <= 7'h00;
            PMEM_ADDR_O <= 15'h0000;
            PMEM_RD_O <= 1'b0;
            pmem_ok_r <= 1'b0;
        end else begin
            PMEM_RD_O <= 1'b0;
            if (state_r == VIA_IDLE && state_nxt == VIA_VHI) begin
                vec_addr_r <= {vis_blk_hi[6:0], arb_code};
                PMEM_ADDR_O <= {vis_blk_hi[6:0], arb_code};
                PMEM_RD_O <= 1'b1;
                pmem_ok_r <= {1'b0, vis_blk_hi[6:0], arb_code} < 16'(PROG_BYTES);
            end else if (state_r == VIA_VHI) begin
                PMEM_ADDR_O <= vec_addr_r + `VIA_PC_ONE;
                PMEM_RD_O <= 1'b1;
                pmem_ok_r <= {1'b0, vec_addr_r + `VIA_PC_ONE} < 16'(PROG_BYTES);
            end
            if (state_r == VIA_VLO) begin
                vec_hi_r <= pmem_data[6:0];
            end
        end
    end
    assign pmem_data = pmem_ok_r ? PMEM_DATA_I : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Program counter loads
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            PC_O <= '0;
        end else begin
            PC_O.load <= 1'b0;
            if (state_r == VIA_ACK && ack_cnt_r == `VIA_ACK_CYCLES) begin
                PC_O.load <= 1'b1;
                PC_O.value <= `VIA_PC_ACK;
            end else if (state_r == VIA_VDONE) begin
                PC_O.load <= 1'b1;
                PC_O.value <= {vec_hi_r, pmem_data};
            end else if (state_r == VIA_IDLE && CORE_I.pop && CORE_I.sp >= `VIA_SP_LIMIT) begin
                PC_O.load <= 1'b1;
                PC_O.value <= `VIA_PC_OVERFLOW;
            end
        end
    end

endmodule

// File: verification/via_arbiter_properties.sv
/*
 * Checker for the vectored interrupt arbiter: vector fetch, acknowledge,
 * trap push and stack underflow timing at the top ports.
 * Assumes one clock domain and one instr_start pulse for each instruction.
 */
module via_arbiter_props
    import via_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    input wire via_core_s CORE_I,
    input wire via_pc_s PC_O,
    input wire via_push_s PUSH_O,
    input wire logic BUSY_O,
    input wire logic [14:0] PMEM_ADDR_O,
    input wire logic PMEM_RD_O,
    input wire logic [7:0] PMEM_DATA_I
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RESET_I);

    ////////////////////////////////////////////////////////////////////////
    // Helper history
    logic [7:0] data_d1_r;
    logic [7:0] data_d2_r;
    logic [14:0] vis_addr_r;
    logic vis_seen_r;

    always_ff @(posedge REF_CLK_I) begin
        data_d1_r <= PMEM_DATA_I;
        data_d2_r <= data_d1_r;
    end

    always_ff @(posedge REF_CLK_I) begin
        vis_addr_r <= CORE_I.instr_addr;
        vis_seen_r <= CORE_I.vectored_select_instr & CORE_I.instr_start & ~RESET_I;
    end

    ////////////////////////////////////////////////////////////////////////
    // Vector fetch steps
    sequence hi_fetch_s;
        PMEM_RD_O && !PMEM_ADDR_O[0];
    endsequence

    sequence pair_fetch_s;
        hi_fetch_s ##1 (PMEM_RD_O && PMEM_ADDR_O[0]);
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    vis_code_range_a: assert property (
        PMEM_RD_O && !$past(PMEM_RD_O) |-> !PMEM_ADDR_O[0] && PMEM_ADDR_O[7:5] == 3'b111)
        else $error("vector code odd or below e0");
    vis_block_a: assert property (
        vis_seen_r ##0 hi_fetch_s |-> PMEM_ADDR_O[14:8] == vis_addr_r[14:8] + 7'(vis_addr_r[7:0] == 8'hff))
        else $error("vector table block wrong");
    vec_pair_a: assert property (
        hi_fetch_s |=> PMEM_RD_O && PMEM_ADDR_O == $past(PMEM_ADDR_O) + 15'h0001)
        else $error("low vector byte not at next address");
    vec_load_a: assert property (
        pair_fetch_s |=> ##1 (PC_O.load && PC_O.value == {data_d2_r[6:0], data_d1_r}))
        else $error("fetched vector not loaded");
    ack_load_a: assert property (
        PUSH_O.push |-> ##7 (PC_O.load && PC_O.value == 15'h00ff))
        else $error("acknowledge load missing");
    ack_busy_a: assert property (
        PUSH_O.push |-> BUSY_O [*7] ##1 !BUSY_O)
        else $error("acknowledge length wrong");
    push_addr_a: assert property (
        PUSH_O.push |-> $past(CORE_I.instr_start) && PUSH_O.addr == $past(CORE_I.instr_addr))
        else $error("pushed address wrong");
    underflow_pc_a: assert property (
        CORE_I.pop && CORE_I.sp >= 8'h6f && !BUSY_O |=> PC_O.load && PC_O.value == 15'h7fff)
        else $error("underflow load missing");
endmodule

bind via_arbiter via_arbiter_props u_props (
    .REF_CLK_I(REF_CLK_I),
    .RESET_I(RESET_I),
    .CORE_I(CORE_I),
    .PC_O(PC_O),
    .PUSH_O(PUSH_O),
    .BUSY_O(BUSY_O),
    .PMEM_ADDR_O(PMEM_ADDR_O),
    .PMEM_RD_O(PMEM_RD_O),
    .PMEM_DATA_I(PMEM_DATA_I)
);

// File: verification/via_pmem_model.sv
/*
 * Program memory model: a byte one cycle after each read strobe.
 * Assumes a registered read strobe; the byte is low address xor block.
 */
module via_pmem_model (
    input wire logic clk_i,
    input wire logic rd_i,
    input wire logic [14:0] addr_i,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial data_o = 8'h00;

    // Inverted filler outside the valid cycle
    always @(posedge clk_i) begin
        if (rd_i) begin
            data_o <= addr_i[7:0] ^ {1'b0, addr_i[14:8]};
        end else begin
            data_o <= ~data_o;
        end
    end
endmodule

// File: verification/tb_vectored_interrupt_arbiter.sv
/*
 * Self-checking bench of the vectored interrupt arbiter.
 * Assumes zero wait APB slave and the program memory model beside it.
 */
`include "via_map.svh"
module tb_vectored_interrupt_arbiter import via_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    via_core_s core = '0;
    logic [4:0] src_evt = 5'h00;
    logic ext_pin = 1'b0;
    logic [7:0] wake_pin = 8'h00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    via_pc_s pc;
    via_push_s push;
    logic busy;
    logic [14:0] pmem_addr;
    logic pmem_rd;
    logic [7:0] pmem_data;
    logic wakeup;
    logic [31:0] rd_data;
    logic rd_err;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] codes [8] = '{8'hfa, 8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hf0, 8'he2, 8'he0};

    via_arbiter #(.PROG_BYTES(4096)) dut_u (.REF_CLK_I(ref_clk), .RESET_I(reset), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .CORE_I(core), .PC_O(pc), .PUSH_O(push), .BUSY_O(busy),
        .PMEM_ADDR_O(pmem_addr), .PMEM_RD_O(pmem_rd), .PMEM_DATA_I(pmem_data), .SRC_EVT_I(src_evt),
        .EXT_IRQ_PIN_I(ext_pin), .WAKE_PIN_I(wake_pin), .WAKEUP_O(wakeup));
    via_pmem_model pmem_u (.clk_i(ref_clk), .rd_i(pmem_rd), .addr_i(pmem_addr), .data_o(pmem_data));

    initial forever #4 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic conclude;
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic core_pulse(input logic [14:0] a, input logic [7:0] op, input logic [3:0] f);
        @(posedge ref_clk);
        core <= '{1'b1, a, op, f[0], f[1], f[2], f[3], 8'h6f};
        @(posedge ref_clk);
        core <= '0;
        #1;
    endtask

    task automatic wait_load(output int n);
        n = 0;
        while (pc.load !== 1'b1 && n < 20) begin
            @(posedge ref_clk); #1; n++;
        end
    endtask

    task automatic wait_idle;
        while (busy !== 1'b0) begin
            @(posedge ref_clk);
            #1;
        end
    endtask

    task automatic run_instr(input logic [14:0] a, input logic [7:0] op, input logic [3:0] f, input logic ep);
        int n;
        core_pulse(a, op, f);
        chk("push", 32'(ep), 32'(push.push));
        if (ep) begin
            chk("push addr", 32'(a), 32'(push.addr));
            wait_load(n);
            chk("ack cycles", 7, n);
            chk("ack pc", 32'h00ff, 32'(pc.value));
        end
        wait_idle();
    endtask

    task automatic do_vis(input logic [14:0] a, input logic [7:0] code);
        int n;
        logic [14:0] base;
        logic [7:0] hi;
        logic [7:0] lo;
        base = {a[14:8] + 7'(a[7:0] == 8'hff), code};
        hi = base[7:0] ^ {1'b0, base[14:8]};
        lo = (base[7:0] + 8'h01) ^ {1'b0, base[14:8]};
        core_pulse(a, 8'hb4, 4'h1);
        wait_load(n);
        chk("vis cycles", 3, n);
        chk("vis pc", 32'({hi[6:0], lo}), 32'(pc.value));
        wait_idle();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        // Reset values, unmapped word
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset read", (i == 2) ? 32'h0000_00e0 : 32'h0, rd_data);
            chk("slverr", 32'(i == 6), 32'(rd_err));
        end
        // Default vector in same and next block
        do_vis(15'h0150, 8'he0);
        do_vis(15'h02ff, 8'he0);
        // All sources active, ranked in turn
        apb(1'b1, `VIA_OFS_CTRL, 32'h3f02);
        apb(1'b1, `VIA_OFS_WAKE_ENABLE_REG, 32'h09);
        apb(1'b1, `VIA_OFS_WAKE_EDGE_SELECT_REG, 32'h08);
        @(posedge ref_clk);
        src_evt <= 5'h1f; ext_pin <= 1'b1; wake_pin <= 8'h0b;
        @(posedge ref_clk);
        src_evt <= 5'h00;
        repeat (8) @(posedge ref_clk);
        apb(1'b0, `VIA_OFS_WAKE_PENDING_REG, 32'h0);
        chk("wake rise", 32'h03, rd_data);
        @(posedge ref_clk);
        wake_pin <= 8'h03;
        repeat (8) @(posedge ref_clk);
        apb(1'b0, `VIA_OFS_WAKE_PENDING_REG, 32'h0);
        chk("wake fall", 32'h0b, rd_data);
        chk("wakeup on", 32'h1, 32'(wakeup));
        apb(1'b0, `VIA_OFS_PEND, 32'h0);
        chk("pend all", 32'h3f, rd_data);
        for (int i = 0; i < 8; i++) begin
            do_vis(15'h0150, codes[i]);
            if (i < 6) apb(1'b1, `VIA_OFS_PEND, 32'(1 << i));
            else apb(1'b1, `VIA_OFS_WAKE_PENDING_REG, 32'h09);
        end
        chk("wakeup off", 32'h0, 32'(wakeup));
        // Stack underflow
        core_pulse(15'h0200, 8'h8e, 4'h8);
        chk("underflow pc", 32'h17fff, {15'h0, pc.load, 1'b0, pc.value});
        wait_idle();
        // External pin on falling edge
        apb(1'b1, `VIA_OFS_CTRL, 32'h0004);
        @(posedge ref_clk);
        ext_pin <= 1'b0;
        repeat (8) @(posedge ref_clk);
        apb(1'b0, `VIA_OFS_PEND, 32'h0);
        chk("ext fall", 32'h01, rd_data);
        apb(1'b1, `VIA_OFS_PEND, 32'h01);
        // Trap, lockout, clear, acknowledge, return
        apb(1'b1, `VIA_OFS_CTRL, 32'h0203);
        run_instr(15'h0456, 8'h00, 4'h0, 1'b1);
        apb(1'b0, `VIA_OFS_CTRL, 32'h0);
        chk("gie after trap", 32'h1, 32'(rd_data[0]));
        @(posedge ref_clk);
        src_evt <= 5'h01;
        @(posedge ref_clk);
        src_evt <= 5'h00;
        run_instr(15'h0460, 8'h42, 4'h0, 1'b0);
        do_vis(15'h0470, 8'hfe);
        run_instr(15'h0471, 8'h42, 4'h2, 1'b0);
        run_instr(15'h0480, 8'h42, 4'h0, 1'b1);
        apb(1'b0, `VIA_OFS_CTRL, 32'h0);
        chk("gie after ack", 32'h0, 32'(rd_data[0]));
        apb(1'b1, `VIA_OFS_PEND, 32'h02);
        run_instr(15'h0490, 8'h42, 4'h4, 1'b0);
        apb(1'b0, `VIA_OFS_CTRL, 32'h0);
        chk("gie after return", 32'h1, 32'(rd_data[0]));
        run_instr(15'h1000, 8'h77, 4'h0, 1'b1);
        run_instr(15'h0010, 8'h42, 4'h2, 1'b0);
        conclude();
    end
endmodule
